// [serial_flash_interface_states.sv]
// interface state machine of a serial multi-i/o flash memory
`timescale 1ns/10ps
`default_nettype none
`include "sfi_defs.svh"
// Contract
// - chip select high: standby, inputs ignored
// - opcode taken msb first on rising clock
// - protect pin sampled only for register writes
// - opcode picks space and transfer format
// - pause low freezes command unless quad mode
// - pause ignores lines 0/1, floats them
// - pause release resumes the frozen phase
// - single input uses line 0, line 1 floats
// - latency count from two-bit latency code
// - latency cycles ignore and float all lines
// - single output on line 1 until deselect
// - dual i/o address two bits, then latency
// - dual latency ends in dual output
// - dual output on lines 0/1 until deselect
// - quad program/output read address on line 0 only
// - quad program to quad input, read to latency
// - quad input four bits per clock
// - quad latency ends in quad output
// - quad output on lines 0..3 until deselect
// - quad mode drops pause/protect, allows quad
module serial_flash_interface_states (
	input  wire logic               mclk,
	input  wire logic               nrst,
	input  wire sfi_pkg::pins_in_t  pin_in,
	output var  sfi_pkg::pins_out_t pin_out,
	input  wire logic               quad_enable,
	input  wire logic [1:0]         read_latency_code,
	input  wire logic [7:0]         tx_data,
	output logic                    tx_load,
	output logic [7:0]              opcode,
	output logic                    opcode_valid,
	output logic [7:0]              rx_data,
	output logic                    rx_valid,
	output logic                    wp_level,
	output sfi_pkg::phase_t         phase,
	output logic                    paused
);

	localparam sfi_pkg::state_t RST0 = '{
		st:      sfi_pkg::ST_IDLE,
		after:   sfi_pkg::ST_IDLE,
		lat_out: sfi_pkg::ST_IDLE,
		sclk_s1: 1'b0,
		cs_s1:   1'b1,
		cs_s2:   1'b1,
		wp_level: 1'b1,
		io_oe_n: `OE_NONE,
		default: '0
	};

	sfi_pkg::state_t r_reg;
	sfi_pkg::state_t r_next;
	sfi_pkg::phase_t cur;
	logic            rise;
	logic            fall;
	logic            cs_hi;
	logic            hold;
	logic            is_out;
	logic [7:0]      opc_n;
	logic [7:0]      lat_n;
	logic [7:0]      byte_v;
	logic [3:0]      din;
	logic [3:0]      rx_sum;
	logic [3:0]      w;
	logic [3:0]      left;
	logic [3:0]      mask;

	// edges of the synchronised serial clock
	assign rise  = r_reg.sclk_s2 & ~r_reg.sclk_s3;
	assign fall  = ~r_reg.sclk_s2 & r_reg.sclk_s3;
	assign cs_hi = r_reg.cs_s2;
	// line 3 is a pause input only outside quad mode
	assign hold  = ~quad_enable & ~r_reg.io_s2[3] & ~cs_hi;

	// latency count from the code; zero means straight to output
	always_comb begin
		unique case (read_latency_code)
			2'h0: lat_n = `LAT_CYC_0;
			2'h1: lat_n = `LAT_CYC_1;
			2'h2: lat_n = `LAT_CYC_2;
			2'h3: lat_n = `LAT_CYC_3;
		endcase
	end

	// leaving standby and capturing an edge in the same cycle is allowed
	assign cur = (r_reg.st == sfi_pkg::ST_IDLE) ? sfi_pkg::ST_INSTR
		: r_reg.st;
	assign is_out = (cur == sfi_pkg::ST_SOUT) | (cur == sfi_pkg::ST_DOUT)
		| (cur == sfi_pkg::ST_QOUT);

	// bits per clock and the lines that carry them
	always_comb begin
		w    = 4'h1;
		din  = {3'h0, r_reg.io_s2[0]};
		mask = `OE_SINGLE;
		if (cur == sfi_pkg::ST_DIN || cur == sfi_pkg::ST_DOUT) begin
			w    = 4'h2;
			din  = {2'h0, r_reg.io_s2[1:0]};
			mask = `OE_DUAL;
		end
		if (cur == sfi_pkg::ST_QIN || cur == sfi_pkg::ST_QOUT) begin
			w    = 4'h4;
			din  = r_reg.io_s2;
			mask = `OE_QUAD;
		end
	end

	assign opc_n  = {r_reg.opc[6:0], r_reg.io_s2[0]};
	assign rx_sum = r_reg.rx_cnt + w;
	assign left   = (r_reg.tx_left == 4'h0) ? `BYTE_BITS : r_reg.tx_left;
	assign byte_v = (r_reg.tx_left == 4'h0) ? tx_data : r_reg.tx_sh;

	// next state of the whole block
	always_comb begin
		r_next           = r_reg;
		r_next.sclk_s1   = pin_in.sclk;
		r_next.sclk_s2   = r_reg.sclk_s1;
		r_next.sclk_s3   = r_reg.sclk_s2;
		r_next.cs_s1     = pin_in.cs_n;
		r_next.cs_s2     = r_reg.cs_s1;
		r_next.io_s1     = pin_in.data_line;
		r_next.io_s2     = r_reg.io_s1;
		r_next.opc_valid = 1'b0;
		r_next.rx_valid  = 1'b0;
		r_next.tx_load   = 1'b0;
		if (cs_hi) begin
			// deselect aborts any phase; nothing else is looked at
			r_next.st      = sfi_pkg::ST_IDLE;
			r_next.cnt     = 8'h00;
			r_next.rx_cnt  = 4'h0;
			r_next.tx_left = 4'h0;
			r_next.drv     = 1'b0;
		end else if (hold) begin
			// frozen as if the clock stood low: no edge is taken
			r_next.st = r_reg.st;
		end else begin
			r_next.st = cur;
			if (rise) begin
				r_next.cnt = r_reg.cnt + 8'h01;
				unique case (cur)
					sfi_pkg::ST_INSTR: begin
						r_next.opc = opc_n;
						if (r_reg.cnt == `INSTR_LAST) begin
							r_next.opc_valid = 1'b1;
							r_next.cnt       = 8'h00;
							r_next.use_lat   = 1'b1;
							r_next.lim       = `ADDR_CLK_SINGLE;
							r_next.st        = sfi_pkg::ST_SIN;
							// format and address width by opcode
							unique case (opc_n)
								`OPC_READ: begin
									r_next.after   = sfi_pkg::ST_SOUT;
									r_next.use_lat = 1'b0;
								end
								`OPC_FAST_READ: begin
									r_next.after = sfi_pkg::ST_SOUT;
								end
								`OPC_DUAL_OUT_RD: begin
									r_next.after = sfi_pkg::ST_DOUT;
								end
								`OPC_DUAL_IO_RD: begin
									r_next.st    = sfi_pkg::ST_DIN;
									r_next.lim   = `ADDR_CLK_DUAL;
									r_next.after = sfi_pkg::ST_DOUT;
								end
								`OPC_QUAD_OUT_RD: begin
									r_next.after = sfi_pkg::ST_QOUT;
									if (!quad_enable) begin
										r_next.st = sfi_pkg::ST_DONE;
									end
								end
								`OPC_QUAD_IO_RD: begin
									r_next.st    = sfi_pkg::ST_QIN;
									r_next.lim   = `ADDR_CLK_QUAD;
									r_next.after = sfi_pkg::ST_QOUT;
									if (!quad_enable) begin
										r_next.st = sfi_pkg::ST_DONE;
									end
								end
								`OPC_QUAD_PROG: begin
									r_next.after   = sfi_pkg::ST_QIN;
									r_next.use_lat = 1'b0;
									if (!quad_enable) begin
										r_next.st = sfi_pkg::ST_DONE;
									end
								end
								`OPC_PAGE_PROG: begin
									r_next.lim = `UNBOUNDED;
								end
								`OPC_WRITE_REGS: begin
									r_next.lim = `UNBOUNDED;
									// protect pin matters only here
									r_next.wp_level = quad_enable
										| r_reg.io_s2[2];
								end
								default: begin
									// standalone or unknown: wait for deselect
									r_next.st = sfi_pkg::ST_DONE;
								end
							endcase
						end
					end
					sfi_pkg::ST_SIN, sfi_pkg::ST_DIN, sfi_pkg::ST_QIN: begin
						// assemble bytes for the core, msb first
						r_next.rx_sh  = 8'((r_reg.rx_sh << w) | {4'h0, din});
						r_next.rx_cnt = rx_sum;
						if (rx_sum == `BYTE_BITS) begin
							r_next.rx_valid = 1'b1;
							r_next.rx_data  = r_next.rx_sh;
							r_next.rx_cnt   = 4'h0;
						end
						if (r_reg.lim != `UNBOUNDED
							&& r_next.cnt == r_reg.lim) begin
							r_next.cnt = 8'h00;
							r_next.lim = `UNBOUNDED;
							r_next.st  = r_reg.after;
							if (r_reg.use_lat && lat_n != 8'h00) begin
								r_next.st      = sfi_pkg::ST_LAT;
								r_next.lat_out = r_reg.after;
							end
						end
					end
					sfi_pkg::ST_LAT: begin
						// line levels are not looked at here
						if (r_next.cnt >= lat_n) begin
							r_next.cnt = 8'h00;
							r_next.st  = r_reg.lat_out;
						end
					end
					default: begin
						r_next.cnt = r_reg.cnt;
					end
				endcase
			end
			// drive on the falling edge so the host samples on the rise
			if (fall && is_out) begin
				r_next.tx_load = (r_reg.tx_left == 4'h0);
				r_next.drv     = 1'b1;
				r_next.tx_sh   = 8'(byte_v << w);
				r_next.tx_left = left - w;
				unique case (cur)
					sfi_pkg::ST_SOUT: begin
						r_next.io_out = {2'h0, byte_v[7], 1'b0};
					end
					sfi_pkg::ST_DOUT: begin
						r_next.io_out = {2'h0, byte_v[7:6]};
					end
					default: begin
						r_next.io_out = byte_v[7:4];
					end
				endcase
			end
		end
		// lines float outside output phases and throughout a pause
		r_next.io_oe_n = `OE_NONE;
		if (!cs_hi && !hold && is_out && r_next.drv) begin
			r_next.io_oe_n = mask;
		end
	end

	// one register for the whole state
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			r_reg <= RST0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign pin_out      = '{io_out: r_reg.io_out, io_oe_n: r_reg.io_oe_n};
	assign tx_load      = r_reg.tx_load;
	assign opcode       = r_reg.opc;
	assign opcode_valid = r_reg.opc_valid;
	assign rx_data      = r_reg.rx_data;
	assign rx_valid     = r_reg.rx_valid;
	assign wp_level     = r_reg.wp_level;
	assign phase        = r_reg.st;
	assign paused       = hold;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);

	chk_standby_on_cs: assert property (cs_hi |=>
		r_reg.st == sfi_pkg::ST_IDLE)
		else $error("not in standby after deselect");

	chk_opcode_eighth: assert property (
		rise && !hold && !cs_hi && r_reg.st == sfi_pkg::ST_INSTR
		&& r_reg.cnt == `INSTR_LAST |=> opcode_valid
		&& opcode == $past(opc_n))
		else $error("opcode not complete on eighth edge");

	chk_wp_only_instr: assert property (
		$changed(wp_level) |-> $past(r_reg.st) inside
		{sfi_pkg::ST_INSTR, sfi_pkg::ST_IDLE})
		else $error("protect level moved outside instruction");

	chk_pause_freeze: assert property (hold |=>
		r_reg.st == $past(r_reg.st) && r_reg.cnt == $past(r_reg.cnt))
		else $error("phase moved during pause");

	chk_pause_float: assert property (hold |=>
		pin_out.io_oe_n == `OE_NONE)
		else $error("line driven during pause");

	chk_input_float: assert property (
		r_reg.st inside {sfi_pkg::ST_INSTR, sfi_pkg::ST_SIN,
		sfi_pkg::ST_DIN, sfi_pkg::ST_QIN, sfi_pkg::ST_LAT}
		|-> pin_out.io_oe_n == `OE_NONE)
		else $error("line driven in input or latency phase");

	chk_quad_gate: assert property (
		opcode_valid
		&& opcode inside {`OPC_QUAD_OUT_RD, `OPC_QUAD_IO_RD, `OPC_QUAD_PROG}
		|-> (phase == sfi_pkg::ST_DONE) == !$past(quad_enable))
		else $error("quad command gate broken");

	chk_out_on_fall: assert property (
		$changed(pin_out.io_out) |-> $past(fall))
		else $error("output changed off a falling edge");

	chk_dual_lines: assert property (
		r_reg.st == sfi_pkg::ST_DOUT && r_reg.drv && !hold && !cs_hi
		&& $past(r_reg.st) == sfi_pkg::ST_DOUT && $past(r_reg.drv)
		&& !$past(hold) && !$past(cs_hi) |-> pin_out.io_oe_n == `OE_DUAL)
		else $error("dual output lines not driven");

endmodule : serial_flash_interface_states
`default_nettype wire

// [serial_flash_interface_states_tb.sv]
// self-checking bench for the flash interface state machine
`timescale 1ns/10ps
`default_nettype none
`include "sfi_defs.svh"
module serial_flash_interface_states_tb;
	logic               mclk = 1'h0;
	logic               nrst = 1'h0;
	logic               quad_enable = 1'h0;
	logic [1:0]         read_latency_code = 2'h0;
	logic [7:0]         tx_data = 8'h96;
	logic [7:0]         e;
	logic [31:0]        v;
	logic [31:0]        w;
	logic [31:0]        rx_acc = 32'h0;
	int                 n;
	int                 error_cnt = 0;
	int                 checks = 0;
	int                 opc_cnt = 0;
	int                 pause_cyc = 0;
	sfi_pkg::pins_in_t  pin_in;
	sfi_pkg::pins_out_t pin_out;
	sfi_pkg::phase_t    phase;
	logic [7:0]         opcode;
	logic [7:0]         rx_data;
	logic               tx_load;
	logic               opcode_valid;
	logic               rx_valid;
	logic               wp_level;
	logic               paused;

	initial begin
		forever #5 mclk = ~mclk;
	end

	// core side: next read byte after each take, received bytes kept
	always @(posedge mclk) begin
		if (tx_load === 1'h1)
			tx_data <= tx_data + 8'h01;
		if (rx_valid === 1'h1)
			rx_acc <= {rx_acc[23:0], rx_data};
		if (opcode_valid === 1'h1)
			opc_cnt <= opc_cnt + 1;
		if (paused === 1'h1)
			pause_cyc <= pause_cyc + 1;
	end

	serial_flash_interface_states DUT (
		.mclk             (mclk),
		.nrst             (nrst),
		.pin_in           (pin_in),
		.pin_out          (pin_out),
		.quad_enable      (quad_enable),
		.read_latency_code(read_latency_code),
		.tx_data          (tx_data),
		.tx_load          (tx_load),
		.opcode           (opcode),
		.opcode_valid     (opcode_valid),
		.rx_data          (rx_data),
		.rx_valid         (rx_valid),
		.wp_level         (wp_level),
		.phase            (phase),
		.paused           (paused)
	);

	sfi_host_model host (
		.mclk   (mclk),
		.pin_out(pin_out),
		.pin_in (pin_in)
	);

	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		checks++;
		if (g !== x) begin
			error_cnt++;
			$display("ERROR at %0t: got %h expected %h", $time, g, x);
		end
	endtask : chk

	task automatic wrap_up();
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : wrap_up

	task automatic t_standby();
		int p;
		repeat (3) host.clk(4'h0, 4'hf);
		chk(32'(phase), 32'(sfi_pkg::ST_IDLE));
		chk(32'({pin_out.io_oe_n, wp_level}), 32'h1f);
		p = opc_cnt;
		host.sel(8'h06);
		chk(32'(opcode), 32'h06);
		chk(32'(opc_cnt - p), 32'h1);
		host.desel();
		chk(32'(phase), 32'(sfi_pkg::ST_IDLE));
		// page program stays in single input until deselect
		host.sel(`OPC_PAGE_PROG);
		host.send(32'ha5, 8, 1);
		chk(32'(phase), 32'(sfi_pkg::ST_SIN));
		chk(rx_acc & 32'hff, 32'ha5);
		host.desel();
		$display("standby done");
	endtask : t_standby

	task automatic t_read();
		int p;
		host.sel(`OPC_READ);
		chk(32'(opcode), 32'(`OPC_READ));
		host.send(32'h5a3c81, 24, 1);
		e = tx_data;
		chk(32'(pin_out.io_oe_n), 32'(`OE_NONE));
		chk(rx_acc & 32'hffffff, 32'h5a3c81);
		host.recv(4, 1, v);
		p = pause_cyc;
		host.hold(3);
		chk(32'(host.hq), 32'(`OE_NONE));
		chk(32'(pause_cyc != p), 32'h1);
		chk(32'(paused), 32'h0);
		host.recv(12, 1, w);
		chk(32'({v[3:0], w[11:0]}), 32'({e, e + 8'h01}));
		chk(32'(pin_out.io_oe_n), 32'(`OE_SINGLE));
		host.desel();
		chk(32'(phase), 32'(sfi_pkg::ST_IDLE));
		$display("read with pause done");
	endtask : t_read

	task automatic t_latency();
		for (int c = 0; c < 4; c++) begin
			read_latency_code <= 2'(c);
			host.sel(`OPC_FAST_READ);
			host.send(32'h0, 24, 1);
			for (n = 0; n < 9; n++) begin
				host.clk(4'hc, 4'hc);
				if (pin_out.io_oe_n !== `OE_NONE)
					break;
			end
			chk(32'(n), 32'(2 * c));
			if (n > 8)
				wrap_up();
			host.desel();
		end
		$display("latency done");
	endtask : t_latency

	task automatic t_dual();
		read_latency_code <= 2'h1;
		host.sel(`OPC_DUAL_IO_RD);
		host.send(32'hc3a5f00f, 32, 2);
		chk(rx_acc, 32'hc3a5f00f);
		host.recv(4, 2, v);
		e = tx_data;
		chk(32'(pin_out.io_oe_n), 32'(`OE_NONE));
		host.recv(8, 2, v);
		chk(v, 32'(e));
		chk(32'(pin_out.io_oe_n), 32'(`OE_DUAL));
		host.desel();
		// dual output read: address on line 0, no latency, data on two lines
		read_latency_code <= 2'h0;
		host.sel(`OPC_DUAL_OUT_RD);
		host.send(32'h13579b, 24, 1);
		e = tx_data;
		host.recv(8, 2, v);
		chk(v, 32'(e));
		host.desel();
		$display("dual done");
	endtask : t_dual

	// protect level counts only at the register write opcode
	task automatic t_wp();
		host.sel(`OPC_WRITE_REGS);
		host.wp = 1'h0;
		host.send(32'h0, 8, 1);
		chk(32'(wp_level), 32'h1);
		host.desel();
		host.sel(`OPC_WRITE_REGS);
		chk(32'(wp_level), 32'h0);
		host.desel();
		$display("protect done");
	endtask : t_wp

	task automatic t_quad();
		int p;
		host.sel(`OPC_QUAD_OUT_RD);
		host.send(32'h0, 24, 1);
		chk(32'(phase), 32'(sfi_pkg::ST_DONE));
		host.desel();
		quad_enable <= 1'h1;
		read_latency_code <= 2'h0;
		host.sel(`OPC_WRITE_REGS);
		chk(32'(wp_level), 32'h1);
		host.desel();
		host.wp = 1'h1;
		host.sel(`OPC_QUAD_OUT_RD);
		host.send(32'h0f1e2d, 24, 1);
		e = tx_data;
		chk(rx_acc & 32'hffffff, 32'h0f1e2d);
		host.recv(8, 4, v);
		chk(v, 32'(e));
		chk(32'(pin_out.io_oe_n), 32'(`OE_QUAD));
		host.desel();
		host.sel(`OPC_QUAD_PROG);
		host.send(32'h7e, 24, 1);
		p = pause_cyc;
		host.send(32'hb4d2, 16, 4);
		chk(32'(pause_cyc - p), 32'h0);
		chk(rx_acc, 32'h007eb4d2);
		chk(32'(phase), 32'(sfi_pkg::ST_QIN));
		host.desel();
		chk(32'(phase), 32'(sfi_pkg::ST_IDLE));
		// quad i/o read with two latency clocks before the data
		read_latency_code <= 2'h1;
		host.sel(`OPC_QUAD_IO_RD);
		host.send(32'h12345678, 32, 4);
		chk(rx_acc, 32'h12345678);
		host.recv(8, 4, v);
		e = tx_data;
		chk(32'(pin_out.io_oe_n), 32'(`OE_NONE));
		host.recv(8, 4, v);
		chk(v, 32'(e));
		host.desel();
		$display("quad done");
	endtask : t_quad

	initial begin
		repeat (6) @(posedge mclk);
		nrst <= 1'h1;
		repeat (4) @(posedge mclk);
		t_standby();
		t_read();
		t_latency();
		t_dual();
		t_wp();
		t_quad();
		wrap_up();
	end

	// hang guard
	initial begin
		#400000;
		error_cnt++;
		wrap_up();
	end
endmodule : serial_flash_interface_states_tb
`default_nettype wire

// [sfi_defs.svh]
// constants for the serial flash interface state machine
`ifndef SFI_DEFS_SVH
`define SFI_DEFS_SVH

// opcodes of the supported commands
`define OPC_READ        8'h03
`define OPC_FAST_READ   8'h0b
`define OPC_DUAL_OUT_RD 8'h3b
`define OPC_QUAD_OUT_RD 8'h6b
`define OPC_DUAL_IO_RD  8'hbb
`define OPC_QUAD_IO_RD  8'heb
`define OPC_QUAD_PROG   8'h32
`define OPC_PAGE_PROG   8'h02
`define OPC_WRITE_REGS  8'h01

// clock counts of the address (plus mode) phases
`define INSTR_LAST      8'h07
`define ADDR_CLK_SINGLE 8'h18
`define ADDR_CLK_DUAL   8'h10
`define ADDR_CLK_QUAD   8'h08
`define UNBOUNDED       8'h00

// latency cycles per read latency code
`define LAT_CYC_0       8'h00
`define LAT_CYC_1       8'h02
`define LAT_CYC_2       8'h04
`define LAT_CYC_3       8'h06

// bits per byte and output enable masks (low = driven)
`define BYTE_BITS       4'h8
`define OE_NONE         4'hf
`define OE_SINGLE       4'hd
`define OE_DUAL         4'hc
`define OE_QUAD         4'h0

`endif

// [sfi_host_model.sv]
// host spi controller model that drives the flash pins
`timescale 1ns/10ps
`default_nettype none
module sfi_host_model (
	input  wire logic               mclk,
	input  wire sfi_pkg::pins_out_t pin_out,
	output var  sfi_pkg::pins_in_t  pin_in
);
	logic       sclk = 1'h0;
	logic       cs_n = 1'h1;
	logic       wp   = 1'h1;
	logic [3:0] hd   = 4'hc;
	logic [3:0] he   = 4'hc;
	logic [3:0] q;
	logic [3:0] hq;

	// a released line shows the last host value where he is set, its inverse where he is clear
	assign pin_in = {sclk, cs_n, ~pin_out.io_oe_n & pin_out.io_out
		| pin_out.io_oe_n & (he & hd | ~he & ~hd)};

	// one 80 ns clock; sampled late in the high half, where data stands
	task automatic clk(input logic [3:0] d, input logic [3:0] e);
		hd <= d;
		he <= e;
		repeat (4) @(posedge mclk);
		sclk <= 1'h1;
		repeat (3) @(posedge mclk);
		@(negedge mclk);
		q = pin_in.data_line;
		@(posedge mclk);
		sclk <= 1'h0;
	endtask : clk

	// msb first; single mode puts junk on line 1, which must be ignored
	task automatic send(input logic [31:0] v, input int n, input int w);
		for (int i = n - w; i >= 0; i -= w) begin
			if (w == 4)
				clk(v[i+:4], 4'hf);
			else if (w == 2)
				clk({1'h1, wp, v[i+:2]}, 4'hf);
			else
				clk({1'h1, wp, ~v[i], v[i]}, 4'hf);
		end
		repeat (2) @(posedge mclk);
	endtask : send

	// lines float from the first listening clock on
	task automatic recv(input int n, input int w, output logic [31:0] v);
		v = '0;
		for (int i = 0; i < n; i += w) begin
			clk({1'h1, wp, 2'h0}, w == 4 ? 4'h0 : 4'hc);
			v = v << w | 32'(w == 4 ? q : w == 2 ? {2'h0, q[1:0]} : {3'h0, q[1]});
		end
	endtask : recv

	// select, then shift the opcode in on line 0
	task automatic sel(input logic [7:0] opc);
		cs_n <= 1'h0;
		repeat (4) @(posedge mclk);
		send({24'h0, opc}, 8, 1);
	endtask : sel

	// deselect only after the last rising edge of the frame
	task automatic desel();
		repeat (4) @(posedge mclk);
		cs_n <= 1'h1;
		repeat (6) @(posedge mclk);
	endtask : desel

	// pause with the clock still toggling; enables recorded meanwhile
	task automatic hold(input int n);
		repeat (8) @(posedge mclk);
		hd[3] <= 1'h0;
		repeat (4) @(posedge mclk);
		repeat (n) clk({1'h0, wp, 2'h0}, 4'hc);
		hq = pin_out.io_oe_n;
		// a release that meets the last fall would let that fall through
		repeat (4) @(posedge mclk);
		hd[3] <= 1'h1;
		repeat (8) @(posedge mclk);
	endtask : hold
endmodule : sfi_host_model
`default_nettype wire

// [sfi_pkg.sv]
// types shared by the serial flash interface state machine
package sfi_pkg;

	// interface phases, one-hot
	typedef enum logic [9:0] {
		ST_IDLE  = 10'h001,
		ST_INSTR = 10'h002,
		ST_SIN   = 10'h004,
		ST_DIN   = 10'h008,
		ST_QIN   = 10'h010,
		ST_LAT   = 10'h020,
		ST_SOUT  = 10'h040,
		ST_DOUT  = 10'h080,
		ST_QOUT  = 10'h100,
		ST_DONE  = 10'h200
	} phase_t;

	// pins from the host: data_line_3 doubles as pause, line 2 as protect
	typedef struct packed {
		logic       sclk;
		logic       cs_n;
		logic [3:0] data_line;
	} pins_in_t;

	// pins toward the host
	typedef struct packed {
		logic [3:0] io_out;
		logic [3:0] io_oe_n;
	} pins_out_t;

	// whole state of the block
	typedef struct packed {
		phase_t     st;
		phase_t     after;
		phase_t     lat_out;
		logic       use_lat;
		logic [7:0] lim;
		logic [7:0] cnt;
		logic       sclk_s1;
		logic       sclk_s2;
		logic       sclk_s3;
		logic       cs_s1;
		logic       cs_s2;
		logic [3:0] io_s1;
		logic [3:0] io_s2;
		logic [7:0] opc;
		logic       opc_valid;
		logic       wp_level;
		logic [7:0] rx_sh;
		logic [3:0] rx_cnt;
		logic [7:0] rx_data;
		logic       rx_valid;
		logic [7:0] tx_sh;
		logic [3:0] tx_left;
		logic       tx_load;
		logic       drv;
		logic [3:0] io_out;
		logic [3:0] io_oe_n;
	} state_t;

endpackage : sfi_pkg
